// ==== core/spirsd_top.sv ====
// Purpose: SPI master receive path, status flags, mirror and delay register
// Assumes: Link clock derived internally, ready and data pins sampled
// Notes:   Mode 0, word length set in control bits 7:3 (sixteen when zero), MSB first, optional parity bit
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Function
// - In master mode a ready timeout after select sets bit 25 of the receive buffer.
// - A ready timeout drops the chip select to inactive at once.
// - Reading the received word clears the timeout flag.
// - Bit 24 holds the length error flag; no logic ever sets it, so it always reads zero.
// - Parity status reads one on a mismatch and zero otherwise.
// - Reserved bits of buffer and mirror read zero and ignore writes.
// - The received word sits right-justified in bits 15 to 0 for any length.
// - The shift register is copied to the received word only when the transfer ends.
// - The mirror register shows only the received word of the receive buffer, in bits 15:0, with the flags reading zero.
// - Reading the mirror leaves every status flag as it was.
// - Delay register holds select-to-transmit in 31:24 and transmit-to-deselect in 23:16.
// - Delay register holds ready release in 15:8 and select-to-ready wait in 7:0.
// - Received parity is checked against parity computed over the data word.
// - The driven data pin is sampled at the receive point and a mismatch flagged.
// - Ready dropping before the last receive point or late after the word flags desync.
// - Select-to-transmit delay lasts the field plus two cycles, or nothing when zero.
module spirsd_top
	import spirsd_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Interrupt
	output logic             irq,
	// SPI link
	output logic             spi_clk,
	output logic             chip_select_n,
	output logic             mosi,
	input  wire logic        mosi_return,
	input  wire logic        miso,
	input  wire logic        slave_ready_line_n
);
	logic                ready_s;
	logic                miso_s;
	logic                mret_s;
	logic [31:0]         delay_reg;
	logic [7:0]          ctrl_reg;
	logic [15:0]         received_word_reg;
	logic                length_error_flag_reg;
	logic                parity_error_flag_reg;
	logic                bit_mismatch_flag_reg;
	logic                desync_flag_reg;
	logic                timeout_flag_reg;
	logic [IRQ_W-1:0]    irq_stat_reg;
	logic [IRQ_W-1:0]    irq_mask_reg;
	spirsd_state_t       state_reg;
	logic [15:0]         shift_reg;
	logic [15:0]         tx_reg;
	logic [4:0]          bit_cnt_reg;
	logic [3:0]          div_reg;
	logic                par_acc_reg;
	logic                par_err_cur;
	logic                bit_err_cur;
	logic                desync_cur;
	logic                len_err_cur;
	logic                word_done;
	logic                timeout_ev;
	logic                desync_late_ev;
	logic                half_tick;
	logic                c2t_start;
	logic                c2t_done;
	logic                c2e_start;
	logic                c2e_done;
	logic                t2e_start;
	logic                t2e_busy;
	logic                t2c_start;
	logic                t2c_done;
	logic                rd_rxbuf;
	logic [31:0]         rxbuf_view;
	logic [31:0]         rdata_next;
	logic [IRQ_W-1:0]    irq_ev;
	logic                go;
	logic                par_en;
	logic                par_odd;
	logic [4:0]          char_len;

	// Control: bit0 go, bit1 parity enable, bit2 odd parity, bits 7:3 length
	assign par_en   = ctrl_reg[1];
	assign par_odd  = ctrl_reg[2];
	assign char_len = (ctrl_reg[7:3] == 5'h00) ? 5'(CHAR_LEN) : ctrl_reg[7:3];

	// Input synchronisers
	spirsd_sync u_sync_rdy (.clock(clock), .rst(rst), .din(slave_ready_line_n), .dout(ready_s));
	spirsd_sync u_sync_miso (.clock(clock), .rst(rst), .din(miso), .dout(miso_s));
	spirsd_sync u_sync_mret (.clock(clock), .rst(rst), .din(mosi_return), .dout(mret_s));

	// Delay counters
	spirsd_delay u_c2t (.clock(clock), .rst(rst), .start(c2t_start),
		.count((delay_reg[C2T_LSB+7:C2T_LSB] == 8'h00) ? 9'h000 :
			{1'b0, delay_reg[C2T_LSB+7:C2T_LSB]} + C2T_EXTRA),
		.abort(1'b0), .done(c2t_done), .busy());
	spirsd_delay u_c2e (.clock(clock), .rst(rst), .start(c2e_start),
		.count({1'b0, delay_reg[C2E_LSB+7:C2E_LSB]}), .abort(1'b0),
		.done(c2e_done), .busy());
	spirsd_delay u_t2e (.clock(clock), .rst(rst), .start(t2e_start),
		.count({1'b0, delay_reg[T2E_LSB+7:T2E_LSB]} + T2E_EXTRA), .abort(1'b0),
		.done(), .busy(t2e_busy));
	spirsd_delay u_t2c (.clock(clock), .rst(rst), .start(t2c_start),
		.count({1'b0, delay_reg[T2C_LSB+7:T2C_LSB]}), .abort(1'b0),
		.done(t2c_done), .busy());

	// Bit clock divider, one half period per pulse
	assign half_tick = (div_reg == 4'h0);
	always_ff @(posedge clock) begin
		if (rst || state_reg != SR_SHIFT) begin
			div_reg <= 4'h7;
		end else begin
			div_reg <= half_tick ? 4'h7 : div_reg - 4'h1;
		end
	end

	assign go         = ctrl_reg[0];
	assign c2e_start  = (state_reg == SR_IDLE) && go;
	assign c2t_start  = c2e_start;
	assign timeout_ev = (state_reg == SR_WAIT || state_reg == SR_C2T) && c2e_done
		&& ready_s;
	assign word_done  = (state_reg == SR_SHIFT) && half_tick && spi_clk
		&& (bit_cnt_reg == char_len + (par_en ? 5'h01 : 5'h00) - 5'h01);
	assign t2e_start  = word_done;
	assign t2c_start  = word_done;
	assign desync_late_ev = (state_reg == SR_HOLD) && !t2e_busy && !ready_s;

	// Transfer sequencer
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg     <= SR_IDLE;
			chip_select_n <= 1'b1;
			spi_clk       <= 1'b0;
			bit_cnt_reg   <= 5'h00;
		end else begin
			case (state_reg)
				SR_IDLE: begin
					if (go) begin
						chip_select_n <= 1'b0;
						state_reg     <= SR_C2T;
						bit_cnt_reg   <= 5'h00;
					end
				end
				SR_C2T: begin
					if (timeout_ev) begin
						chip_select_n <= 1'b1;
						state_reg     <= SR_IDLE;
					end else if (c2t_done) begin
						state_reg <= SR_WAIT;
					end
				end
				SR_WAIT: begin
					if (timeout_ev) begin
						chip_select_n <= 1'b1;
						state_reg     <= SR_IDLE;
					end else if (!ready_s && !c2t_start) begin
						state_reg <= SR_SHIFT;
					end
				end
				SR_SHIFT: begin
					if (half_tick) begin
						spi_clk <= !spi_clk;
						if (spi_clk) begin
							bit_cnt_reg <= bit_cnt_reg + 5'h01;
						end
					end
					if (word_done) begin
						spi_clk   <= 1'b0;
						state_reg <= SR_HOLD;
					end
				end
				SR_HOLD: begin
					if (t2c_done || !t2e_busy) begin
						chip_select_n <= 1'b1;
						state_reg     <= SR_IDLE;
					end
				end
				default: begin
					state_reg <= SR_IDLE;
				end
			endcase
		end
	end

	// Shift, parity, bit check, desync for the current word
	always_ff @(posedge clock) begin
		if (rst || state_reg == SR_IDLE) begin
			shift_reg   <= 16'h0000;
			tx_reg      <= 16'h0000;
			mosi        <= 1'b0;
			par_acc_reg <= 1'b0;
			par_err_cur <= 1'b0;
			bit_err_cur <= 1'b0;
			desync_cur  <= 1'b0;
			len_err_cur <= 1'b0;
		end else if (state_reg == SR_SHIFT && half_tick) begin
			if (!spi_clk) begin
				if (bit_cnt_reg < char_len) begin
					shift_reg   <= {shift_reg[14:0], miso_s};
					par_acc_reg <= par_acc_reg ^ miso_s;
				end else if (par_en) begin
					par_err_cur <= (par_acc_reg ^ par_odd) != miso_s;
				end
				if (mret_s != mosi) begin
					bit_err_cur <= 1'b1;
				end
				if (ready_s) begin
					desync_cur <= 1'b1;
				end
			end else begin
				mosi   <= tx_reg[15];
				tx_reg <= {tx_reg[14:0], 1'b0};
			end
		end else if (state_reg == SR_SHIFT && ready_s) begin
			desync_cur <= 1'b1;
		end
	end

	assign rd_rxbuf = avs_read && !avs_waitrequest && avs_address[5:4] == PAGE_MAIN
		&& avs_address[3:0] == OFF_RXBUF && avs_byteenable[1:0] != 2'b00;

	// Received word and its flags, loaded together at the end of a word
	always_ff @(posedge clock) begin
		if (rst) begin
			received_word_reg     <= 16'h0000;
			parity_error_flag_reg <= 1'b0;
			bit_mismatch_flag_reg <= 1'b0;
			desync_flag_reg       <= 1'b0;
			length_error_flag_reg <= 1'b0;
		end else if (word_done) begin
			received_word_reg     <= shift_reg;
			parity_error_flag_reg <= par_err_cur;
			bit_mismatch_flag_reg <= bit_err_cur;
			desync_flag_reg       <= desync_cur;
			length_error_flag_reg <= len_err_cur;
		end else if (rd_rxbuf) begin
			parity_error_flag_reg <= 1'b0;
			bit_mismatch_flag_reg <= 1'b0;
			desync_flag_reg       <= desync_late_ev;
			length_error_flag_reg <= 1'b0;
		end else if (desync_late_ev) begin
			desync_flag_reg <= 1'b1;
		end
	end

	// Timeout flag: set wins over read clear
	always_ff @(posedge clock) begin
		if (rst) begin
			timeout_flag_reg <= 1'b0;
		end else if (timeout_ev) begin
			timeout_flag_reg <= 1'b1;
		end else if (rd_rxbuf) begin
			timeout_flag_reg <= 1'b0;
		end
	end

	// Reserved bits 23:16 forced to zero
	assign rxbuf_view = {3'b000, bit_mismatch_flag_reg, desync_flag_reg, parity_error_flag_reg,
		timeout_flag_reg, length_error_flag_reg, 8'h00, received_word_reg};

	// Delay and control registers
	always_ff @(posedge clock) begin
		if (rst) begin
			delay_reg <= DELAY_RESET;
			ctrl_reg  <= 8'h00;
		end else begin
			if (avs_write && !avs_waitrequest && avs_address[5:4] == PAGE_MAIN) begin
				if (avs_address[3:0] == OFF_DELAY) begin
					for (int i = 0; i < 4; i++) begin
						if (avs_byteenable[i]) begin
							delay_reg[i*8 +: 8] <= avs_writedata[i*8 +: 8];
						end
					end
				end else if (avs_address[3:0] == OFF_CTRL && avs_byteenable[0]) begin
					ctrl_reg <= avs_writedata[7:0];
				end
			end
			if ((state_reg == SR_HOLD || timeout_ev) && ctrl_reg[0]) begin
				ctrl_reg[0] <= 1'b0;
			end
		end
	end

	// Interrupt status and mask
	assign irq_ev = {par_err_cur & word_done, bit_err_cur & word_done,
		(desync_cur & word_done) | desync_late_ev, timeout_ev, word_done};
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			irq          <= 1'b0;
		end else begin
			if (avs_read && !avs_waitrequest && avs_address[5:4] == PAGE_IRQ
				&& avs_address[3:0] == OFF_IRQ_STAT) begin
				irq_stat_reg <= irq_ev;
			end else begin
				irq_stat_reg <= irq_stat_reg | irq_ev;
			end
			if (avs_write && !avs_waitrequest && avs_address[5:4] == PAGE_IRQ
				&& avs_address[3:0] == OFF_IRQ_MASK && avs_byteenable[0]) begin
				irq_mask_reg <= avs_writedata[IRQ_W-1:0];
			end
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Read mux
	always_comb begin
		rdata_next = UNMAPPED_VAL;
		if (avs_address[5:4] == PAGE_MAIN && avs_address[3:0] == OFF_RXBUF) begin
			rdata_next = rxbuf_view;
		end else if (avs_address[5:4] == PAGE_MAIN && avs_address[3:0] == OFF_MIRROR) begin
			rdata_next = {16'h0000, rxbuf_view[15:0]};
		end else if (avs_address[5:4] == PAGE_MAIN && avs_address[3:0] == OFF_DELAY) begin
			rdata_next = delay_reg;
		end else if (avs_address[5:4] == PAGE_MAIN && avs_address[3:0] == OFF_CTRL) begin
			rdata_next = {24'h00_0000, ctrl_reg};
		end else if (avs_address[5:4] == PAGE_IRQ && avs_address[3:0] == OFF_IRQ_STAT) begin
			rdata_next = {27'h000_0000, irq_stat_reg};
		end else if (avs_address[5:4] == PAGE_IRQ && avs_address[3:0] == OFF_IRQ_MASK) begin
			rdata_next = {27'h000_0000, irq_mask_reg};
		end
	end

	// Bus handshake: one wait cycle, data registered at the release edge
	always_ff @(posedge clock) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= rdata_next;
			end
		end
	end
endmodule : spirsd_top

// ==== core/spirsd_pkg.sv ====
// Purpose: Constants for the SPI receive status and delay block
// Assumes: 32-bit Avalon-MM register bus, 100 MHz clock
// Notes:   Offsets are byte addresses
package spirsd_pkg;
	localparam logic [3:0]  OFF_RXBUF    = 4'h0;
	localparam logic [3:0]  OFF_MIRROR   = 4'h4;
	localparam logic [3:0]  OFF_DELAY    = 4'h8;
	localparam logic [3:0]  OFF_CTRL     = 4'hC;
	localparam logic [3:0]  OFF_IRQ_STAT = 4'h0;
	localparam logic [3:0]  OFF_IRQ_MASK = 4'h4;
	localparam logic [1:0]  PAGE_MAIN    = 2'h0;
	localparam logic [1:0]  PAGE_IRQ     = 2'h1;
	localparam int          BIT_BIT_MISMATCH_FLAG   = 28;
	localparam int          BIT_DESYNC   = 27;
	localparam int          BIT_PARITY_ERROR_FLAG   = 26;
	localparam int          BIT_TIMEOUT  = 25;
	localparam int          BIT_LENGTH_ERROR_FLAG  = 24;
	localparam int          C2T_LSB      = 24;
	localparam int          T2C_LSB      = 16;
	localparam int          T2E_LSB      = 8;
	localparam int          C2E_LSB      = 0;
	localparam logic [31:0] DELAY_RESET  = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
	localparam logic [8:0]  C2T_EXTRA    = 9'h002;
	localparam logic [8:0]  T2E_EXTRA    = 9'h001;
	localparam int          CHAR_LEN     = 16;
	// Interrupt status bits
	localparam int          IRQ_RX       = 0;
	localparam int          IRQ_TIMEOUT  = 1;
	localparam int          IRQ_DESYNC   = 2;
	localparam int          IRQ_BIT_MISMATCH_FLAG   = 3;
	localparam int          IRQ_PARITY_ERROR_FLAG   = 4;
	localparam int          IRQ_W        = 5;
	typedef enum logic [2:0] {SR_IDLE, SR_C2T, SR_WAIT, SR_SHIFT, SR_HOLD} spirsd_state_t;
endpackage : spirsd_pkg

// ==== core/spirsd_sync.sv ====
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Asynchronous input to clock
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
module spirsd_sync
	import spirsd_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Data
	input  wire logic din,
	output logic      dout
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			dout   <= 1'b1;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				dout <= s3_reg;
			end
		end
	end
endmodule : spirsd_sync

// ==== core/spirsd_delay.sv ====
// Purpose: Loadable down counter for link timing
// Assumes: Load and start in one pulse
// Notes:   Done pulses once when the count expires
`timescale 1ns/1ps
module spirsd_delay
	import spirsd_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Control
	input  wire logic       start,
	input  wire logic [8:0] count,
	input  wire logic       abort,
	output logic            done,
	output logic            busy
);
	logic [8:0] cnt_reg;

	always_ff @(posedge clock) begin
		if (rst || abort) begin
			cnt_reg <= 9'h000;
			busy    <= 1'b0;
			done    <= 1'b0;
		end else if (start) begin
			cnt_reg <= count;
			busy    <= (count != 9'h000);
			done    <= (count == 9'h000);
		end else if (busy) begin
			cnt_reg <= cnt_reg - 9'h001;
			done    <= (cnt_reg == 9'h001);
			busy    <= (cnt_reg != 9'h001);
		end else begin
			done    <= 1'b0;
		end
	end
endmodule : spirsd_delay

// ==== dv/spirsd_asserts.sv ====
// Purpose: Port checker for spirsd_top
// Assumes: Byte addresses and pages as in the package
// Notes:   Bound to every spirsd_top below
`timescale 1ns/1ps
module spirsd_asserts
	import spirsd_pkg::*;
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// Bus
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        irq,
	// Link
	input wire logic        spi_clk,
	input wire logic        chip_select_n,
	input wire logic        mosi,
	input wire logic        mosi_return,
	input wire logic        miso,
	input wire logic        slave_ready_line_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire         rd_buf  = avs_read && !avs_waitrequest && avs_address == {PAGE_MAIN, OFF_RXBUF};
	wire         rd_mir  = avs_read && !avs_waitrequest && avs_address == {PAGE_MAIN, OFF_MIRROR};
	wire         irq_ack = (avs_read || avs_write) && !avs_waitrequest && avs_address[5:4] == PAGE_IRQ;
	logic [31:0] dly;
	logic [15:0] lword;
	logic [9:0]  wcnt;
	logic        clr_seen, wvalid, ck_seen;
	// Delay setting as last written
	always_ff @(posedge clock) begin
		if (rst)
			dly <= 32'h0000_0000;
		else if (avs_write && !avs_waitrequest && avs_address == {PAGE_MAIN, OFF_DELAY})
			dly <= avs_writedata;
	end
	// Word and flag state after a buffer read
	always_ff @(posedge clock) begin
		if (rst || !chip_select_n) begin
			clr_seen <= 1'b0;
			wvalid <= 1'b0;
		end else if (rd_buf) begin
			clr_seen <= |avs_byteenable[1:0];
			wvalid <= 1'b1;
			lword <= avs_readdata[15:0];
		end
	end
	// Cycles selected with no ready and no clock
	always_ff @(posedge clock) begin
		if (rst || chip_select_n) begin
			wcnt <= 10'h000;
			ck_seen <= 1'b0;
		end else begin
			ck_seen <= ck_seen | spi_clk;
			wcnt <= (slave_ready_line_n && !ck_seen) ? wcnt + 10'h001 : 10'h000;
		end
	end
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered next cycle");
	ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	rst_quiet_a: assert property (disable iff (1'b0) rst |=> chip_select_n && avs_waitrequest && !irq)
		else $error("outputs not idle after reset");
	buf_resv_a: assert property (rd_buf |-> avs_readdata[24:16] == 9'h000)
		else $error("buffer reserved or length bits set");
	mir_resv_a: assert property (rd_mir |-> avs_readdata[31:16] == 16'h0000)
		else $error("mirror upper bits set");
	flag_clear_a: assert property (rd_buf && clr_seen |-> avs_readdata[28:24] == 5'h00)
		else $error("flags survive a buffer read");
	mirror_word_a: assert property (rd_mir && wvalid |-> avs_readdata[15:0] == lword)
		else $error("mirror word differs from buffer");
	clk_idle_a: assert property (chip_select_n && $past(chip_select_n) |-> !spi_clk)
		else $error("link clock runs while deselected");
	half_bit_a: assert property ($rose(spi_clk) |-> spi_clk[*8] ##1 !spi_clk)
		else $error("link clock high phase not eight cycles");
	sel_wait_a: assert property (wcnt <= {2'h0, dly[31:24]} + {2'h0, dly[7:0]} + 10'h018)
		else $error("select held past ready wait");
	irq_drop_a: assert property ($fell(irq) |-> $past(irq_ack) || $past(irq_ack, 2))
		else $error("irq fell without status or mask access");
	cover property (rd_buf && avs_readdata[26]);
	cover property (rd_buf && avs_readdata[25]);
	cover property (rd_buf && avs_readdata[28]);
endmodule : spirsd_asserts

bind spirsd_top spirsd_asserts u_chk (.clock(clock), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq), .spi_clk(spi_clk),
	.chip_select_n(chip_select_n), .mosi(mosi), .mosi_return(mosi_return), .miso(miso),
	.slave_ready_line_n(slave_ready_line_n));

// ==== dv/spirsd_slave.sv ====
// Purpose: Link slave with ready line
// Assumes: Mode 0, MSB first, parity bit after the word
// Notes:   Ready pulled up when deselected
`timescale 1ns/1ps
module spirsd_slave #(
	parameter logic [7:0] READY_DLY = 8'h05
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// Link
	input wire logic        spi_clk,
	input wire logic        chip_select_n,
	input wire logic        mosi,
	output logic            miso,
	output logic            slave_ready_line_n,
	output logic            mosi_return,
	// Behaviour
	input wire logic [15:0] word,
	input wire logic        par_bit,
	input wire logic        ready_on,
	input wire logic        flip
);
	logic [31:0] sh_reg;
	logic [7:0]  rcnt_reg;
	logic        cs_q, ck_q;
	// Own data pin as seen back, optionally disturbed
	assign mosi_return = mosi ^ flip;
	always @(posedge clock) begin
		cs_q <= chip_select_n;
		ck_q <= spi_clk;
		if (rst || chip_select_n) begin
			slave_ready_line_n <= 1'b1;
			rcnt_reg <= 8'h00;
			miso <= rst ? 1'b0 : ~miso;
		end else begin
			if (cs_q) begin
				sh_reg <= {word, par_bit, 15'h0000};
				miso <= word[15];
			end else if (ck_q && !spi_clk) begin
				sh_reg <= sh_reg << 1;
				miso <= sh_reg[30];
			end
			if (rcnt_reg != READY_DLY)
				rcnt_reg <= rcnt_reg + 8'h01;
			else if (ready_on)
				slave_ready_line_n <= 1'b0;
		end
	end
endmodule : spirsd_slave

// ==== dv/spi_receive_status_and_delay_bench.sv ====
// Purpose: Self-checking bench for spirsd_top
// Assumes: Offsets and pages as in the package
// Notes:   Read results checked from a queue
`timescale 1ns/1ps
module spi_receive_status_and_delay_bench import spirsd_pkg::*;;
	typedef struct {
		logic [31:0] e;
		logic [31:0] m;
		logic [5:0]  a;
	} spirsd_note_t;
	logic        clock, rst, avs_read, avs_write, avs_waitrequest, irq, spi_clk, chip_select_n;
	logic        mosi, mosi_return, miso, slave_ready_line_n, s_par, s_on, s_flip;
	logic [5:0]  avs_address;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, seed, r;
	logic [15:0] s_word;
	spirsd_note_t q[$];
	spirsd_note_t nt;
	int          n_fail, n_tests;

	spirsd_top dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.spi_clk(spi_clk), .chip_select_n(chip_select_n), .mosi(mosi),
		.mosi_return(mosi_return), .miso(miso), .slave_ready_line_n(slave_ready_line_n));
	spirsd_slave peer (.clock(clock), .rst(rst), .spi_clk(spi_clk),
		.chip_select_n(chip_select_n), .mosi(mosi), .miso(miso),
		.slave_ready_line_n(slave_ready_line_n), .mosi_return(mosi_return), .word(s_word),
		.par_bit(s_par), .ready_on(s_on), .flip(s_flip));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	task automatic fail_wait(input string nm);
		n_fail++;
		$display("Error %s: expected answer, seen none", nm);
		close_out();
	endtask : fail_wait

	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, m);
		int i;
		if (!w)
			q.push_back('{d, m, a});
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (i == 50)
			fail_wait("waitrequest");
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask : bus

	task automatic wait_irq();
		int i;
		for (i = 0; i < 4000; i++) begin
			@(posedge clock);
			if (irq === 1'b1)
				break;
		end
		if (i == 4000)
			fail_wait("irq");
	endtask : wait_irq

	task automatic chk(input string nm, input logic e, g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s: expected %b, seen %b", nm, e, g);
		end
	endtask : chk

	task automatic frame(input logic [15:0] w, input logic [7:0] ctl, input logic bad, fl);
		logic [15:0] ew;
		ew = (ctl[7:3] == 5'h08) ? {8'h00, w[15:8]} : w;
		s_word <= w;
		s_par <= ^w ^ ctl[2] ^ bad;
		s_flip <= fl;
		s_on <= 1'b1;
		bus(1, 6'h0C, {24'h00_0000, ctl}, 32'h0000_0000);
		wait_irq();
		bus(0, 6'h04, {16'h0000, ew}, 32'hFFFF_FFFF);
		bus(0, 6'h10, 32'h0000_0001, 32'h0000_0001);
		bus(0, 6'h00, {3'h0, fl, 1'b0, bad, 10'h000, ew}, 32'h1FFF_FFFF);
		bus(0, 6'h00, {16'h0000, ew}, 32'h1FFF_FFFF);
		bus(0, 6'h04, {16'h0000, ew}, 32'hFFFF_FFFF);
	endtask : frame

	// Result checker
	always @(posedge clock) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			nt = q.pop_front();
			n_tests++;
			if ((avs_readdata & nt.m) !== (nt.e & nt.m)) begin
				n_fail++;
				$display("Error readdata at %h: expected %h, seen %h", nt.a, nt.e & nt.m,
					avs_readdata & nt.m);
			end
		end
	end

	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		seed = 32'h0000_D3AB;
		n_fail = 0;
		n_tests = 0;
		s_word = 16'h0000;
		s_par = 1'b0;
		s_on = 1'b1;
		s_flip = 1'b0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		bus(0, 6'h08, 32'h0000_0000, 32'hFFFF_FFFF);
		bus(0, 6'h04, 32'h0000_0000, 32'hFFFF_FFFF);
		r = rnd();
		bus(1, 6'h08, r, 32'h0000_0000);
		bus(0, 6'h08, r, 32'hFFFF_FFFF);
		bus(1, 6'h00, 32'hFFFF_FFFF, 32'h0000_0000);
		bus(1, 6'h04, 32'hFFFF_FFFF, 32'h0000_0000);
		bus(1, 6'h20, 32'hFFFF_FFFF, 32'h0000_0000);
		bus(0, 6'h00, 32'h0000_0000, 32'h00FF_0000);
		bus(0, 6'h04, 32'h0000_0000, 32'hFFFF_FFFF);
		bus(0, 6'h20, 32'h0000_0000, 32'hFFFF_FFFF);
		$display("Test registers done");
		bus(1, 6'h08, 32'h0602_FFFF, 32'h0000_0000);
		bus(1, 6'h14, 32'h0000_001F, 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			frame(r[15:0], {(k == 0) ? 5'h08 : 5'h00, k == 2, k == 1 || k == 2, 1'b1},
				k == 1, k == 3);
		end
		$display("Test frames done");
		s_on <= 1'b0;
		bus(1, 6'h08, 32'h0602_FF0A, 32'h0000_0000);
		bus(1, 6'h0C, 32'h0000_0001, 32'h0000_0000);
		wait_irq();
		chk("chip_select_n", 1'b1, chip_select_n);
		bus(1, 6'h14, 32'h0000_0000, 32'h0000_0000);
		@(posedge clock);
		chk("irq masked", 1'b0, irq);
		bus(1, 6'h14, 32'h0000_001F, 32'h0000_0000);
		@(posedge clock);
		chk("irq unmasked", 1'b1, irq);
		bus(0, 6'h10, 32'h0000_0002, 32'h0000_0002);
		@(posedge clock);
		chk("irq cleared", 1'b0, irq);
		bus(0, 6'h00, 32'h0200_0000, 32'h0200_0000);
		bus(0, 6'h00, 32'h0000_0000, 32'h0200_0000);
		$display("Test timeout done");
		close_out();
	end
endmodule : spi_receive_status_and_delay_bench
